// ### lpmq_cfg.svh
// lpmq_cfg.svh: constants of the low-power exit clock and supervisor flag model
// assumes: included by bare name after the package, 100 MHz core clock
`ifndef LPMQ_CFG_SVH
`define LPMQ_CFG_SVH

// ****************************************************************
// timing
// ****************************************************************
`define LPMQ_CLK_PERIOD_NS    10
`define LPMQ_OVERSHOOT_NS     6000
// longest time, so it rounds down
`define LPMQ_OVERSHOOT_CYCLES (`LPMQ_OVERSHOOT_NS / `LPMQ_CLK_PERIOD_NS)
`define LPMQ_OVS_CNT_W        10

// ****************************************************************
// low power mode codes
// ****************************************************************
`define LPMQ_MODE_W           3
`define LPMQ_MODE_LOW_POWER_MODE_3        3'h3
`define LPMQ_MODE_LOW_POWER_MODE_4        3'h4

// ****************************************************************
// divider and reset values
// ****************************************************************
`define LPMQ_DIV_W            3
`define LPMQ_DIV_CNT_W        5
`define LPMQ_DIV_MAX          3'h5
`define LPMQ_FLAG_EN_RST      2'h3
`define LPMQ_FLAG_RST         2'h0

`endif

// ### lpmq_periph.sv
// lpmq_periph.sv: peripheral clocked from the sub clock tick
// assumes: same clock as lpmq_top, run driven by software model
`timescale 1ns/1ps

module lpmq_periph (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        tick,
  input  wire logic        run,
  output logic             request,
  output logic [15:0]      tick_count
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  always_comb count_next = count_reg + {15'h0, tick};
  always_ff @(posedge clk) count_reg <= reset ? 16'h0 : count_next;
  assign tick_count = count_reg;
  // a halted module drops its request so nothing runs on the sub clock in deep sleep
  assign request = run;
endmodule // lpmq_periph

// ### lpmq_pkg.sv
// lpmq_pkg.sv: types shared by the low-power exit model
// assumes: compiled before the design modules
package lpmq_pkg;

  typedef enum logic [1:0] {
    LPMQ_ACTIVE = 2'b00,
    LPMQ_LIGHT  = 2'b01,
    LPMQ_DEEP   = 2'b10,
    LPMQ_WAKE   = 2'b11
  } lpmq_state_t;

  typedef enum logic {
    LPMQ_SRC_OSC = 1'b0,
    LPMQ_SRC_XT2 = 1'b1
  } lpmq_src_t;

endpackage

// ### lpmq_tick_gen.sv
// lpmq_tick_gen.sv: divided clock-enable generator for one derived clock
// assumes: same clock domain as its user, divider is a power-of-two exponent
`timescale 1ns/1ps
`include "lpmq_cfg.svh"

module lpmq_tick_gen
  import lpmq_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      run,
  input  wire logic                      fast,
  input  wire logic [`LPMQ_DIV_W-1:0]    div_log2,
  output logic                           tick
);

  logic [`LPMQ_DIV_CNT_W-1:0] cnt_reg;
  logic [`LPMQ_DIV_CNT_W-1:0] cnt_next;
  logic                       tick_reg;
  logic                       tick_next;
  logic [`LPMQ_DIV_CNT_W-1:0] mask;
  logic [`LPMQ_DIV_W-1:0]     div_sat;

  // ****************************************************************
  // divider
  // ****************************************************************
  always_comb begin
    div_sat   = (div_log2 > `LPMQ_DIV_MAX) ? `LPMQ_DIV_MAX : div_log2;
    mask      = `LPMQ_DIV_CNT_W'((1 << div_sat) - 1);
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (run) begin
      // overshoot ignores the programmed division: every cycle ticks
      if (fast || cnt_reg >= mask) begin
        cnt_next  = '0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + `LPMQ_DIV_CNT_W'(1);
      end
    end else begin
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule // lpmq_tick_gen

// ### lpmq_top.sv
// lpmq_top.sv: low-power exit clock overshoot and supervisor flag enable model
// assumes: RESET is the power-up clear, control inputs come from core logic on CLK,
// comparator events come from analog and are asynchronous
//
// Operation
// - a power-up clear while a supervisor is disabled blocks its supervisor and monitor flags.
// - any write to a supervisor control register after the clear re-enables those flags.
// - on leaving low power mode 3 or 4 the oscillator runs fast for at most 6 us.
// - a sub clock taken from the oscillator is passed ungated during that wake interval.
// - the main clock likewise runs faster than programmed on that exit.
`timescale 1ns/1ps
`include "lpmq_cfg.svh"

module lpmq_top
  import lpmq_pkg::*;
#(
  parameter int unsigned OVERSHOOT_CYCLES = `LPMQ_OVERSHOOT_CYCLES
)
(
  input  wire logic                      CLK,
  input  wire logic                      RESET,
  // supervisor side: index 0 low side, index 1 high side
  input  wire logic [1:0]                SUPERVISOR_ENABLE,
  input  wire logic [1:0]                SUPERVISOR_REG_WRITE,
  input  wire logic [1:0]                SUPPLY_SUPERVISOR_EVENT,
  input  wire logic [1:0]                SUPPLY_MONITOR_EVENT,
  input  wire logic [1:0]                SUPERVISOR_FLAG_CLEAR,
  input  wire logic [1:0]                MONITOR_FLAG_CLEAR,
  // power mode control
  input  wire logic                      SLEEP_REQUEST,
  input  wire logic [`LPMQ_MODE_W-1:0]   SLEEP_MODE,
  input  wire logic                      WAKE_REQUEST,
  // clock control
  input  wire logic                      SUB_CLOCK_SOURCE,
  input  wire logic                      SUB_CLOCK_REQUEST_ENABLE,
  input  wire logic                      SUB_CLOCK_PERIPHERAL_REQUEST,
  input  wire logic [`LPMQ_DIV_W-1:0]    MAIN_CLOCK_DIVIDER,
  input  wire logic [`LPMQ_DIV_W-1:0]    SUB_CLOCK_DIVIDER,
  // status
  output logic [1:0]                     SUPPLY_SUPERVISOR_FLAG,
  output logic [1:0]                     SUPPLY_MONITOR_FLAG,
  output logic [1:0]                     FLAG_FUNCTION_ENABLE,
  output logic [1:0]                     POWER_STATE,
  output logic                           OSCILLATOR_OVERSHOOT,
  output logic                           MAIN_CLOCK_TICK,
  output logic                           SUB_CLOCK_TICK
);

  localparam logic [`LPMQ_OVS_CNT_W-1:0] OVS_LAST = `LPMQ_OVS_CNT_W'(OVERSHOOT_CYCLES - 1);

  // ****************************************************************
  // comparator event synchronisers
  // ****************************************************************
  logic [1:0] sup_meta_reg;
  logic [1:0] sup_sync_reg;
  logic [1:0] mon_meta_reg;
  logic [1:0] mon_sync_reg;

  // no reset: a synchroniser only needs two edges to flush
  always_ff @(posedge CLK) begin
    sup_meta_reg <= SUPPLY_SUPERVISOR_EVENT;
    sup_sync_reg <= sup_meta_reg;
    mon_meta_reg <= SUPPLY_MONITOR_EVENT;
    mon_sync_reg <= mon_meta_reg;
  end

  // ****************************************************************
  // flag enable latches and sticky flags
  // ****************************************************************
  logic [1:0] flag_en_reg;
  logic [1:0] flag_en_next;
  logic [1:0] sup_flag_reg;
  logic [1:0] sup_flag_next;
  logic [1:0] mon_flag_reg;
  logic [1:0] mon_flag_next;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_side
      always_comb begin
        // enable control bits live in the always-on domain, so the clear still sees them
        if (RESET) begin
          flag_en_next[gi] = SUPERVISOR_ENABLE[gi];
        end else if (SUPERVISOR_REG_WRITE[gi]) begin
          flag_en_next[gi] = 1'b1;
        end else begin
          flag_en_next[gi] = flag_en_reg[gi];
        end

        // a set in the same cycle as its clear wins, so no event is lost
        if (RESET) begin
          sup_flag_next[gi] = 1'b0;
          mon_flag_next[gi] = 1'b0;
        end else begin
          sup_flag_next[gi] = (flag_en_reg[gi] & sup_sync_reg[gi]) |
                              (sup_flag_reg[gi] & ~SUPERVISOR_FLAG_CLEAR[gi]);
          mon_flag_next[gi] = (flag_en_reg[gi] & mon_sync_reg[gi]) |
                              (mon_flag_reg[gi] & ~MONITOR_FLAG_CLEAR[gi]);
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK) begin
    flag_en_reg  <= flag_en_next;
    sup_flag_reg <= sup_flag_next;
    mon_flag_reg <= mon_flag_next;
  end

  // ****************************************************************
  // power state and overshoot interval
  // ****************************************************************
  lpmq_state_t                  state_reg;
  lpmq_state_t                  state_next;
  logic [`LPMQ_OVS_CNT_W-1:0]   ovs_cnt_reg;
  logic [`LPMQ_OVS_CNT_W-1:0]   ovs_cnt_next;
  logic                         deep_mode;

  assign deep_mode = (SLEEP_MODE == `LPMQ_MODE_LOW_POWER_MODE_3) || (SLEEP_MODE == `LPMQ_MODE_LOW_POWER_MODE_4);

  always_comb begin
    state_next   = state_reg;
    ovs_cnt_next = ovs_cnt_reg;
    case (state_reg)
      LPMQ_ACTIVE: begin
        if (SLEEP_REQUEST) begin
          state_next = deep_mode ? LPMQ_DEEP : LPMQ_LIGHT;
        end
      end
      LPMQ_LIGHT: begin
        if (WAKE_REQUEST) begin
          state_next = LPMQ_ACTIVE;
        end
      end
      LPMQ_DEEP: begin
        if (WAKE_REQUEST) begin
          // oscillator restarts fast; interval is the longest time rounded down
          state_next   = LPMQ_WAKE;
          ovs_cnt_next = '0;
        end
      end
      LPMQ_WAKE: begin
        if (ovs_cnt_reg >= OVS_LAST) begin
          state_next = LPMQ_ACTIVE;
        end else begin
          ovs_cnt_next = ovs_cnt_reg + `LPMQ_OVS_CNT_W'(1);
        end
      end
      default: begin
        state_next = LPMQ_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg   <= LPMQ_ACTIVE;
      ovs_cnt_reg <= '0;
    end else begin
      state_reg   <= state_next;
      ovs_cnt_reg <= ovs_cnt_next;
    end
  end

  // ****************************************************************
  // derived clock enables
  // ****************************************************************
  logic overshoot;
  logic sub_from_osc;
  logic main_run;
  logic sub_run;
  logic sub_fast;

  assign overshoot    = (state_reg == LPMQ_WAKE);
  assign sub_from_osc = (SUB_CLOCK_SOURCE == LPMQ_SRC_OSC);

  // main clock stops in any sleep state and overshoots on deep exit
  assign main_run = (state_reg == LPMQ_ACTIVE) || overshoot;

  // in deep sleep the sub clock runs only on a granted peripheral request; during
  // the wake interval it is not masked, which is the hazard peripherals see
  assign sub_run  = (state_reg == LPMQ_ACTIVE) || (state_reg == LPMQ_LIGHT) ||
                    overshoot ||
                    ((state_reg == LPMQ_DEEP) && SUB_CLOCK_REQUEST_ENABLE &&
                     SUB_CLOCK_PERIPHERAL_REQUEST);
  // the second crystal does not overshoot, so a sub clock from it keeps its rate
  assign sub_fast = overshoot && sub_from_osc;

  lpmq_tick_gen u_main_tick (
    .clk      (CLK),
    .reset    (RESET),
    .run      (main_run),
    .fast     (overshoot),
    .div_log2 (MAIN_CLOCK_DIVIDER),
    .tick     (MAIN_CLOCK_TICK)
  );

  lpmq_tick_gen u_sub_tick (
    .clk      (CLK),
    .reset    (RESET),
    .run      (sub_run),
    .fast     (sub_fast),
    .div_log2 (SUB_CLOCK_DIVIDER),
    .tick     (SUB_CLOCK_TICK)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign SUPPLY_SUPERVISOR_FLAG = sup_flag_reg;
  assign SUPPLY_MONITOR_FLAG    = mon_flag_reg;
  assign FLAG_FUNCTION_ENABLE   = flag_en_reg;
  assign POWER_STATE            = state_reg;
  assign OSCILLATOR_OVERSHOOT   = overshoot;

endmodule // lpmq_top

// ### lpmq_top_props.sv
// lpmq_top_props.sv: concurrent checks on the ports of lpmq_top
// assumes: bound to every lpmq_top, one clock, RESET synchronous
`timescale 1ns/1ps
`include "lpmq_cfg.svh"

module lpmq_top_props
  import lpmq_pkg::*;
#(
  parameter int unsigned OVERSHOOT_CYCLES = 8
)
(
  input wire logic                    CLK,
  input wire logic                    RESET,
  input wire logic [1:0]              SUPERVISOR_ENABLE,
  input wire logic [1:0]              SUPERVISOR_REG_WRITE,
  input wire logic                    SLEEP_REQUEST,
  input wire logic [`LPMQ_MODE_W-1:0] SLEEP_MODE,
  input wire logic                    WAKE_REQUEST,
  input wire logic                    SUB_CLOCK_SOURCE,
  input wire logic [1:0]              SUPPLY_SUPERVISOR_FLAG,
  input wire logic [1:0]              SUPPLY_MONITOR_FLAG,
  input wire logic [1:0]              FLAG_FUNCTION_ENABLE,
  input wire logic [1:0]              POWER_STATE,
  input wire logic                    OSCILLATOR_OVERSHOOT,
  input wire logic                    MAIN_CLOCK_TICK,
  input wire logic                    SUB_CLOCK_TICK
);
  // wake length counter, wide enough for the full 6 us figure
  logic [15:0] wake_cnt_reg;
  logic [15:0] wake_cnt_next;
  logic        deep_mode;
  assign deep_mode = (SLEEP_MODE == `LPMQ_MODE_LOW_POWER_MODE_3) || (SLEEP_MODE == `LPMQ_MODE_LOW_POWER_MODE_4);
  always_comb wake_cnt_next = (POWER_STATE == LPMQ_WAKE) ? wake_cnt_reg + 16'h1 : 16'h0;
  always_ff @(posedge CLK) wake_cnt_reg <= RESET ? 16'h0 : wake_cnt_next;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  a_clear_loads_en: assert property ($fell(RESET) |-> FLAG_FUNCTION_ENABLE == $past(SUPERVISOR_ENABLE))
    else $error("flag enable not loaded by clear");
  a_write_sets_en: assert property (|SUPERVISOR_REG_WRITE |=>
    (FLAG_FUNCTION_ENABLE & $past(SUPERVISOR_REG_WRITE)) == $past(SUPERVISOR_REG_WRITE))
    else $error("write did not enable flags");
  a_en_sticky: assert property (!$past(RESET) |->
    (FLAG_FUNCTION_ENABLE & $past(FLAG_FUNCTION_ENABLE)) == $past(FLAG_FUNCTION_ENABLE))
    else $error("flag enable dropped without clear");
  a_flag_blocked: assert property (((SUPPLY_SUPERVISOR_FLAG | SUPPLY_MONITOR_FLAG)
    & ~($past(SUPPLY_SUPERVISOR_FLAG) | $past(SUPPLY_MONITOR_FLAG))
    & ~($past(FLAG_FUNCTION_ENABLE) | $past(SUPERVISOR_REG_WRITE))) == 2'h0)
    else $error("flag set while disabled");
  a_deep_entry: assert property (SLEEP_REQUEST && POWER_STATE == LPMQ_ACTIVE && deep_mode
    |=> POWER_STATE == LPMQ_DEEP) else $error("deep sleep not entered");
  a_wake_entry: assert property (WAKE_REQUEST && POWER_STATE == LPMQ_DEEP
    |=> POWER_STATE == LPMQ_WAKE && OSCILLATOR_OVERSHOOT) else $error("no overshoot on deep wake");
  a_overshoot_len: assert property ($fell(OSCILLATOR_OVERSHOOT) |->
    wake_cnt_reg == OVERSHOOT_CYCLES && POWER_STATE == LPMQ_ACTIVE) else $error("overshoot length wrong");
  a_main_fast: assert property (POWER_STATE == LPMQ_WAKE && $past(POWER_STATE) == LPMQ_WAKE
    |-> MAIN_CLOCK_TICK) else $error("main clock not fast in overshoot");
  a_sub_ungated: assert property (POWER_STATE == LPMQ_WAKE && $past(POWER_STATE) == LPMQ_WAKE
    && !SUB_CLOCK_SOURCE && !$past(SUB_CLOCK_SOURCE) |-> SUB_CLOCK_TICK) else $error("sub clock gated");

  c_deep_wake: cover property ($fell(OSCILLATOR_OVERSHOOT));
  c_flag_set: cover property (|SUPPLY_SUPERVISOR_FLAG);
  c_en_write: cover property (|SUPERVISOR_REG_WRITE ##1 &FLAG_FUNCTION_ENABLE);
endmodule // lpmq_top_props

bind lpmq_top lpmq_top_props #(.OVERSHOOT_CYCLES(OVERSHOOT_CYCLES)) i_props (
  .CLK(CLK), .RESET(RESET), .SUPERVISOR_ENABLE(SUPERVISOR_ENABLE), .SUPERVISOR_REG_WRITE(SUPERVISOR_REG_WRITE),
  .SLEEP_REQUEST(SLEEP_REQUEST), .SLEEP_MODE(SLEEP_MODE), .WAKE_REQUEST(WAKE_REQUEST),
  .SUB_CLOCK_SOURCE(SUB_CLOCK_SOURCE), .SUPPLY_SUPERVISOR_FLAG(SUPPLY_SUPERVISOR_FLAG),
  .SUPPLY_MONITOR_FLAG(SUPPLY_MONITOR_FLAG), .FLAG_FUNCTION_ENABLE(FLAG_FUNCTION_ENABLE),
  .POWER_STATE(POWER_STATE), .OSCILLATOR_OVERSHOOT(OSCILLATOR_OVERSHOOT),
  .MAIN_CLOCK_TICK(MAIN_CLOCK_TICK), .SUB_CLOCK_TICK(SUB_CLOCK_TICK));

// ### testbench.sv
// testbench.sv: random and corner tests of lpmq_top
// assumes: lpmq_top_props bound, inputs driven at the falling edge
`timescale 1ns/1ps
`include "lpmq_cfg.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end

module testbench;
  import lpmq_pkg::*;
  localparam int unsigned OVS = 8;
  logic clk, reset, sleep, wake, sub_src, rq_en, run, req;
  logic [1:0] sup_en, wr, sv_ev, mon_ev, sv_clr, mon_clr;
  logic [1:0] sv_flag, mon_flag, flag_en, state;
  logic [2:0] mode, main_div, sub_div;
  logic ovs_flag, main_tick, sub_tick;
  logic [31:0] seed;
  logic [15:0] p_cnt;
  int n_fail = 0;
  int compares = 0;

  lpmq_top #(.OVERSHOOT_CYCLES(OVS)) i_dut (.CLK(clk), .RESET(reset), .SUPERVISOR_ENABLE(sup_en),
    .SUPERVISOR_REG_WRITE(wr), .SUPPLY_SUPERVISOR_EVENT(sv_ev), .SUPPLY_MONITOR_EVENT(mon_ev),
    .SUPERVISOR_FLAG_CLEAR(sv_clr), .MONITOR_FLAG_CLEAR(mon_clr), .SLEEP_REQUEST(sleep),
    .SLEEP_MODE(mode), .WAKE_REQUEST(wake), .SUB_CLOCK_SOURCE(sub_src), .SUB_CLOCK_REQUEST_ENABLE(rq_en),
    .SUB_CLOCK_PERIPHERAL_REQUEST(req), .MAIN_CLOCK_DIVIDER(main_div), .SUB_CLOCK_DIVIDER(sub_div),
    .SUPPLY_SUPERVISOR_FLAG(sv_flag), .SUPPLY_MONITOR_FLAG(mon_flag), .FLAG_FUNCTION_ENABLE(flag_en),
    .POWER_STATE(state), .OSCILLATOR_OVERSHOOT(ovs_flag), .MAIN_CLOCK_TICK(main_tick),
    .SUB_CLOCK_TICK(sub_tick));
  lpmq_periph i_periph (.clk(clk), .reset(reset), .tick(sub_tick), .run(run), .request(req), .tick_count(p_cnt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int exp_ovs(input logic [2:0] m);
    return (m == `LPMQ_MODE_LOW_POWER_MODE_3 || m == `LPMQ_MODE_LOW_POWER_MODE_4) ? OVS : 0;
  endfunction

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************************************
  // supervisor flags
  // ****************************************************************
  task automatic do_reset(input logic [1:0] en);
    sup_en = en;
    reset = 1'b1;
    step(8);
    reset = 1'b0;
    `CHK(flag_en, en)
  endtask
  // events must drain through the synchronisers before the clear, or set wins
  task automatic ev_chk(input logic [1:0] exp);
    sv_ev = 2'h3;
    mon_ev = 2'h3;
    step(4);
    sv_ev = 2'h0;
    mon_ev = 2'h0;
    step(3);
    `CHK(sv_flag, exp)
    `CHK(mon_flag, exp)
    sv_clr = 2'h3;
    mon_clr = 2'h3;
    step(1);
    sv_clr = 2'h0;
    mon_clr = 2'h0;
    step(2);
  endtask
  // ****************************************************************
  // sleep and wake
  // ****************************************************************
  task automatic sleep_wake(input logic [2:0] m, input logic src, input logic [2:0] md, sd, input logic rq);
    int n, mt, st;
    logic p;
    logic [15:0] c0, c1;
    n = 0; mt = 0; st = 0; p = 1'b0;
    c0 = 16'h0;
    c1 = 16'h0;
    sub_src = src; // second crystal avoids the overshoot
    rq_en = rq; // request enable left set in the corner runs
    main_div = md;
    sub_div = sd;
    run = 1'b0; // halt sub clock users before sleeping
    mode = m;
    sleep = 1'b1;
    step(1);
    sleep = 1'b0;
    step(3);
    `CHK(state, (exp_ovs(m) > 0) ? LPMQ_DEEP : LPMQ_LIGHT)
    `CHK(main_tick, 1'b0)
    if (exp_ovs(m) > 0) `CHK(sub_tick, 1'b0)
    wake = 1'b1;
    for (int k = 1; k <= OVS + 4; k++) begin
      @(negedge clk);
      wake = 1'b0;
      // peripheral count lags the tick by one edge, so its window is shifted by one
      if (k == 2) c0 = p_cnt;
      if (k == OVS + 2) c1 = p_cnt;
      if (p) begin
        mt += main_tick;
        st += sub_tick;
      end
      p = ovs_flag;
      n += ovs_flag;
    end
    `CHK(n, exp_ovs(m))
    `CHK(mt, exp_ovs(m))
    if (!src) `CHK(st, exp_ovs(m))
    else `CHK(st <= (exp_ovs(m) >> sd) + 1, 1'b1)
    if (!src && exp_ovs(m) > 0) `CHK(c1 - c0, 16'(OVS))
    `CHK(state, LPMQ_ACTIVE)
    step(exp_ovs(m) > 0 ? 100 : 1); // worst core level wait before re-enabling
    run = 1'b1;
    main_div = 3'h0; // undivided main clock only after that wait
    step(2);
    `CHK(main_tick, 1'b1)
    $display("test sleep mode %0d done", m);
  endtask

  initial begin
    reset = 1'b1; sup_en = 2'h0; wr = 2'h0; sv_ev = 2'h0; mon_ev = 2'h0; sv_clr = 2'h0; mon_clr = 2'h0;
    sleep = 1'b0; wake = 1'b0; mode = 3'h0; sub_src = 1'b0; rq_en = 1'b1; run = 1'b1;
    main_div = 3'h0; sub_div = 3'h0; seed = 32'h077975f0;
    do_reset(2'h1);
    ev_chk(2'h1);
    wr = 2'h2;
    step(1);
    wr = 2'h0;
    `CHK(flag_en, 2'h3)
    ev_chk(2'h3);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      do_reset(seed[1:0]);
      ev_chk(seed[1:0]);
      wr = seed[3:2];
      step(1);
      wr = 2'h0;
      `CHK(flag_en, seed[1:0] | seed[3:2])
      ev_chk(seed[1:0] | seed[3:2]);
    end
    $display("test flag enable done");
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      if (i < 4) sleep_wake(3'(3 + i[0]), i[1], 3'h5, 3'(i), 1'b1);
      else sleep_wake(seed[2:0], seed[3], seed[6:4], seed[9:7], seed[10]);
    end
    tally_and_finish();
  end

  initial begin
    step(8000);
    n_fail++;
    tally_and_finish();
  end
endmodule // testbench
